// [e3ra_pkg.sv]
// Shared constants and types for the receive alarm interrupt block.
`default_nettype none

package e3ra_pkg;

    typedef logic [7:0] e3ra_byte_t;
    typedef logic [3:0] e3ra_cnt_t;

    ////////////////////////////////////////////////////////////////////////
    // Device register map on the link.
    localparam e3ra_byte_t ADDR_DEFECT_CFG = 8'h11;
    localparam e3ra_byte_t ADDR_IRQ_EN = 8'h12;
    localparam e3ra_byte_t ADDR_IRQ_STAT = 8'h14;

    // Fields of the defect state and configuration register.
    localparam int BIT_ALGO = 7;
    localparam int BIT_LOF_ST = 6;
    localparam int BIT_OOF_ST = 5;
    localparam int BIT_LOS_ST = 4;
    localparam int BIT_AIS_ST = 3;
    localparam int BIT_PLD_ST = 2;
    localparam int BIT_TMARK_ST = 1;
    localparam int BIT_FAR_END_RECEIVE_FAILURE_ST = 0;

    // Fields shared by the interrupt enable and status registers.
    localparam int IRQ_W = 5;
    localparam int IRQ_ALIGN = 4;
    localparam int IRQ_OOF = 3;
    localparam int IRQ_LOF = 2;
    localparam int IRQ_LOS = 1;
    localparam int IRQ_AIS = 0;

    ////////////////////////////////////////////////////////////////////////
    // Framing and alarm figures.
    localparam int ALIGN_W = 12;
    localparam logic [2:0] OOF_ERR_FRAMES = 3'h4;
    localparam e3ra_cnt_t AIS_ZERO_LIMIT = 4'h8;
    localparam logic [1:0] AIS_FRAMES = 2'h2;

    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned LOF_SHORT_MS = 1;
    localparam int unsigned LOF_LONG_MS = 3;
    localparam int unsigned LOF_SHORT_CYCLES = CLK_HZ / 1000 * LOF_SHORT_MS;
    localparam int unsigned LOF_LONG_CYCLES = CLK_HZ / 1000 * LOF_LONG_MS;

    typedef enum logic [1:0] {FR_IN_FRAME, FR_OUT_OF_FRAME} e3ra_frame_t;
    typedef enum logic [1:0] {H_IDLE, H_WAIT} e3ra_host_t;

    ////////////////////////////////////////////////////////////////////////
    // Host controller registers on APB.
    localparam e3ra_byte_t APB_CMD = 8'h00;
    localparam e3ra_byte_t APB_STAT = 8'h04;
    localparam e3ra_byte_t APB_ISTAT = 8'h08;
    localparam e3ra_byte_t APB_IMASK = 8'h0C;
    localparam int CMD_WDATA_LSB = 8;
    localparam int CMD_WRITE_BIT = 16;
    localparam int CMD_GO_BIT = 17;
    localparam int STAT_BUSY_BIT = 8;
    localparam int STAT_ALARM_BIT = 9;
    localparam int HIRQ_W = 2;
    localparam int HIRQ_DONE = 0;
    localparam int HIRQ_ALARM = 1;

    // Counts up by one and sticks at the limit.
    function automatic e3ra_cnt_t sat_inc(e3ra_cnt_t cnt, e3ra_cnt_t lim);
        sat_inc = (cnt >= lim) ? lim : cnt + 4'h1;
    endfunction

endpackage

`default_nettype wire

// [e3ra_link_if.sv]
// Register link between the host controller and the alarm device.
`default_nettype none

interface e3ra_link_if;
    logic sel;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ack;
    logic intN;

    modport dev (
        input sel,
        input wr,
        input addr,
        input wdata,
        output rdata,
        output ack,
        output intN
    );

    modport host (
        output sel,
        output wr,
        output addr,
        output wdata,
        input rdata,
        input ack,
        input intN
    );
endinterface

`default_nettype wire

// [e3ra_ais_detect.sv]
// Per-frame zero counting that declares and clears the AIS defect.
`default_nettype none

module e3ra_ais_detect (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic bitValid,
    input wire logic bitData,
    input wire logic frameTick,
    output logic aisState,
    output logic aisChange
);
    import e3ra_pkg::*;

    typedef struct packed {
        e3ra_cnt_t zeroCnt;
        logic [1:0] lowRun;
        logic [1:0] highRun;
        logic ais;
        logic change;
    } e3ra_ais_st_t;

    e3ra_ais_st_t st;
    e3ra_ais_st_t next_st;
    e3ra_cnt_t zeros;
    logic lowFrame;

    always_comb begin
        next_st = st;
        next_st.change = 1'b0;
        lowFrame = 1'b0;
        zeros = (bitValid && !bitData) ? sat_inc(st.zeroCnt, AIS_ZERO_LIMIT)
                                       : st.zeroCnt;
        next_st.zeroCnt = zeros;
        if (frameTick) begin
            // The bit arriving with the frame mark still counts.
            lowFrame = zeros < AIS_ZERO_LIMIT;
            next_st.zeroCnt = '0;
            next_st.lowRun = lowFrame ? ((st.lowRun >= AIS_FRAMES) ?
                             AIS_FRAMES : st.lowRun + 2'h1) : 2'h0;
            next_st.highRun = lowFrame ? 2'h0 : ((st.highRun >= AIS_FRAMES) ?
                              AIS_FRAMES : st.highRun + 2'h1);
            if (!st.ais && next_st.lowRun >= AIS_FRAMES) begin // [RULE_11]
                next_st.ais = 1'b1;
                next_st.change = 1'b1;
            end
            if (st.ais && next_st.highRun >= AIS_FRAMES) begin // [RULE_12]
                next_st.ais = 1'b0;
                next_st.change = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign aisState = st.ais;
    assign aisChange = st.change;
endmodule // e3ra_ais_detect

`default_nettype wire

// [e3ra_device.sv]
// Receive alarm detection, interrupt flags and registers of the device end.
`default_nettype none

//
// Contract
// RULE_01: Enable bit 2 gates frame-loss interrupt.
// RULE_02: Enabled alarm interrupt drives request line low.
// RULE_03: Frame-loss change sets status bit 2.
// RULE_04: Config bit 7 algorithm; bits 6-0 live states.
// RULE_05: Alignment change raises interrupt when enabled.
// RULE_06: Four errored alignment frames declare out-of-frame.
// RULE_07: Out-of-frame keeps old alignment for extraction.
// RULE_08: Alignment interrupt only if new alignment differs.
// RULE_09: Enable bit 4 gates alignment-change interrupt.
// RULE_10: Alignment change sets status bit 4.
// RULE_11: Two frames with seven zeros declare AIS.
// RULE_12: Two frames with eight zeros clear AIS.
// RULE_13: AIS interrupt on both declare and clear.
// RULE_14: Enable bit 0 gates AIS interrupt.
// RULE_15: AIS change sets status bit 0.
// RULE_16: Status bits 7-5 read-only; 4-0 clear on read.
// RULE_17: Host reads live AIS state after interrupt.
// RULE_18: Frame loss after out-of-frame 1 or 3 ms.
// RULE_19: Request line releases when no enabled flag remains.
module e3ra_device #(
    parameter int unsigned LOF_SHORT_CYC = e3ra_pkg::LOF_SHORT_CYCLES,
    parameter int unsigned LOF_LONG_CYC = e3ra_pkg::LOF_LONG_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    e3ra_link_if.dev lnk,
    input wire logic frameTick,
    input wire logic fasError,
    input wire logic resyncDone,
    input wire logic [e3ra_pkg::ALIGN_W-1:0] resyncAlign,
    input wire logic bitValid,
    input wire logic bitData,
    input wire logic losState,
    input wire logic payloadUnstable,
    input wire logic traceMark,
    input wire logic farEndFailure,
    output logic [e3ra_pkg::ALIGN_W-1:0] extractAlign,
    output logic oofState,
    output logic lofState,
    output logic aisState
);
    import e3ra_pkg::*;

    typedef struct packed {
        logic algoSel;
        logic [IRQ_W-1:0] irqEn;
        logic [IRQ_W-1:0] irqStat;
        e3ra_frame_t fst;
        logic out_of_frame;
        logic [2:0] errRun;
        logic [31:0] timer;
        logic loss_of_frame;
        logic [ALIGN_W-1:0] align;
        logic losQ;
        e3ra_byte_t rdata;
        logic ack;
        logic intN;
    } e3ra_dev_st_t;

    localparam e3ra_dev_st_t DEV_RST = '{intN: 1'b1, fst: FR_IN_FRAME,
                                         default: '0};

    e3ra_dev_st_t st;
    e3ra_dev_st_t next_st;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    logic take;
    logic aisChange;
    logic [31:0] lofLimit;
    e3ra_byte_t defectByte;

    ////////////////////////////////////////////////////////////////////////
    // AIS runs on its own zero counter, outside the alignment state machine.
    e3ra_ais_detect u_ais (
        .clock(clock),
        .sys_rst(sys_rst),
        .bitValid(bitValid),
        .bitData(bitData),
        .frameTick(frameTick),
        .aisState(aisState),
        .aisChange(aisChange)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        ev = '0;
        clr = '0;
        take = lnk.sel & ~st.ack;
        next_st.ack = take;
        next_st.losQ = losState;
        lofLimit = st.algoSel ? 32'(LOF_LONG_CYC) : 32'(LOF_SHORT_CYC);

        ev[IRQ_AIS] = aisChange; // [RULE_13]
        ev[IRQ_LOS] = losState ^ st.losQ;

        // Framer alignment tracking.
        unique case (st.fst)
            FR_IN_FRAME: begin
                if (frameTick) begin
                    if (!fasError) begin
                        next_st.errRun = '0;
                    end else if (st.errRun == OOF_ERR_FRAMES - 3'h1) begin
                        next_st.fst = FR_OUT_OF_FRAME; // [RULE_06]
                        next_st.errRun = '0;
                        next_st.timer = '0;
                        ev[IRQ_OOF] = 1'b1;
                    end else begin
                        next_st.errRun = st.errRun + 3'h1;
                    end
                end
            end
            FR_OUT_OF_FRAME: begin
                // The held alignment is only replaced on re-acquisition,
                // so extraction keeps running on the old one meanwhile.
                if (resyncDone) begin
                    next_st.fst = FR_IN_FRAME;
                    next_st.timer = '0;
                    ev[IRQ_OOF] = 1'b1;
                    if (st.loss_of_frame) begin
                        next_st.loss_of_frame = 1'b0;
                        ev[IRQ_LOF] = 1'b1;
                    end
                    if (resyncAlign != st.align) begin // [RULE_08]
                        next_st.align = resyncAlign; // [RULE_07]
                        ev[IRQ_ALIGN] = 1'b1; // [RULE_05]
                    end
                end else if (!st.loss_of_frame) begin
                    next_st.timer = st.timer + 32'h1;
                    if (st.timer + 32'h1 >= lofLimit) begin // [RULE_18]
                        next_st.loss_of_frame = 1'b1;
                        ev[IRQ_LOF] = 1'b1;
                    end
                end
            end
        endcase
        next_st.out_of_frame = next_st.fst == FR_OUT_OF_FRAME;

        // Live defect view; bit 7 is the only writable field here.
        defectByte = '0;
        defectByte[BIT_ALGO] = st.algoSel; // [RULE_04]
        defectByte[BIT_LOF_ST] = st.loss_of_frame;
        defectByte[BIT_OOF_ST] = st.out_of_frame;
        defectByte[BIT_LOS_ST] = st.losQ;
        defectByte[BIT_AIS_ST] = aisState;
        defectByte[BIT_PLD_ST] = payloadUnstable;
        defectByte[BIT_TMARK_ST] = traceMark;
        defectByte[BIT_FAR_END_RECEIVE_FAILURE_ST] = farEndFailure;

        // Register access: one request per sel assertion, answered by ack.
        if (take) begin
            next_st.rdata = '0;
            if (lnk.wr) begin
                if (lnk.addr == ADDR_DEFECT_CFG) begin
                    next_st.algoSel = lnk.wdata[BIT_ALGO];
                end
                if (lnk.addr == ADDR_IRQ_EN) begin
                    // [RULE_01] [RULE_09] [RULE_14]
                    next_st.irqEn = lnk.wdata[IRQ_W-1:0];
                end
            end else begin
                if (lnk.addr == ADDR_DEFECT_CFG) begin
                    next_st.rdata = defectByte;
                end
                if (lnk.addr == ADDR_IRQ_EN) begin
                    next_st.rdata = {{(8 - IRQ_W){1'b0}}, st.irqEn};
                end
                if (lnk.addr == ADDR_IRQ_STAT) begin
                    // [RULE_16]
                    next_st.rdata = {{(8 - IRQ_W){1'b0}}, st.irqStat};
                    clr = st.irqStat;
                end
            end
        end

        // A flag raised in the cycle of its read-clear survives the read.
        // [RULE_03] [RULE_10] [RULE_15]
        next_st.irqStat = (st.irqStat & ~clr) | (ev & st.irqEn);
        // [RULE_02] [RULE_19]
        next_st.intN = ~|(next_st.irqStat & next_st.irqEn);
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st <= DEV_RST;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign lnk.rdata = st.rdata;
    assign lnk.ack = st.ack;
    assign lnk.intN = st.intN;
    assign extractAlign = st.align;
    assign oofState = st.out_of_frame;
    assign lofState = st.loss_of_frame;
endmodule // e3ra_device

`default_nettype wire

// [e3ra_host.sv]
// Host controller: APB registers that drive the device register link.
`default_nettype none

module e3ra_host (
    input wire logic clock,
    input wire logic sys_rst,
    e3ra_link_if.host lnk,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    import e3ra_pkg::*;

    typedef struct packed {
        e3ra_host_t hs;
        logic sel;
        logic wr;
        e3ra_byte_t addr;
        e3ra_byte_t wdata;
        e3ra_byte_t rdByte;
        logic busy;
        logic [HIRQ_W-1:0] istat;
        logic [HIRQ_W-1:0] imask;
        logic irq;
        logic intNq;
        logic pready;
        logic [31:0] prdata;
    } e3ra_host_st_t;

    localparam e3ra_host_st_t HOST_RST = '{hs: H_IDLE, intNq: 1'b1,
                                           default: '0};

    e3ra_host_st_t st;
    e3ra_host_st_t next_st;
    logic [HIRQ_W-1:0] ev;
    logic [HIRQ_W-1:0] w1c;
    logic [31:0] rd;

    always_comb begin
        next_st = st;
        ev = '0;
        w1c = '0;
        rd = '0;
        next_st.intNq = lnk.intN;
        ev[HIRQ_ALARM] = st.intNq & ~lnk.intN;

        // One-wait-state data is prepared in the first access cycle.
        next_st.pready = psel & penable & ~st.pready;
        if (psel && penable && !st.pready) begin
            if (!pwrite) begin
                unique case (paddr)
                    APB_CMD: rd = {14'h0000, st.busy, st.wr,
                                   st.wdata, st.addr};
                    APB_STAT: begin
                        rd[7:0] = st.rdByte;
                        rd[STAT_BUSY_BIT] = st.busy;
                        rd[STAT_ALARM_BIT] = ~st.intNq;
                    end
                    APB_ISTAT: rd = 32'(st.istat);
                    APB_IMASK: rd = 32'(st.imask);
                    default: rd = '0;
                endcase
            end
            next_st.prdata = rd;
        end

        // Writes act only at the edge where pready is seen high.
        if (psel && penable && st.pready && pwrite) begin
            if (paddr == APB_CMD && !st.busy && pwdata[CMD_GO_BIT]) begin
                // [RULE_01] [RULE_09] [RULE_14]
                next_st.addr = pwdata[7:0];
                next_st.wdata = pwdata[CMD_WDATA_LSB +: 8];
                next_st.wr = pwdata[CMD_WRITE_BIT];
                next_st.sel = 1'b1;
                next_st.busy = 1'b1;
                next_st.hs = H_WAIT;
            end
            if (paddr == APB_ISTAT) begin
                w1c = pwdata[HIRQ_W-1:0];
            end
            if (paddr == APB_IMASK) begin
                next_st.imask = pwdata[HIRQ_W-1:0];
            end
        end

        unique case (st.hs)
            H_IDLE: begin
            end
            H_WAIT: begin
                if (lnk.ack) begin
                    next_st.sel = 1'b0;
                    next_st.busy = 1'b0;
                    next_st.hs = H_IDLE;
                    ev[HIRQ_DONE] = 1'b1;
                    if (!st.wr) begin
                        next_st.rdByte = lnk.rdata;
                    end
                end
            end
        endcase

        next_st.istat = (st.istat & ~w1c) | ev;
        next_st.irq = |(next_st.istat & next_st.imask);
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st <= HOST_RST;
        end else begin
            st <= next_st;
        end
    end

    assign lnk.sel = st.sel;
    assign lnk.wr = st.wr;
    assign lnk.addr = st.addr;
    assign lnk.wdata = st.wdata;
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = 1'b0;
    assign irq = st.irq;
endmodule // e3ra_host

`default_nettype wire

// [e3ra_checker.sv]
// Assertions on the register link between host controller and device.
`default_nettype none

module e3ra_checker
    import e3ra_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic sel,
    input wire logic wr,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic ack,
    input wire logic intN
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    logic [4:0] enCopy;
    logic algoCopy;
    logic take;
    assign take = sel && !ack;

    // Shadows of the writable bits, updated at the edge a write is taken.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            enCopy <= 5'h00;
            algoCopy <= 1'b0;
        end else if (take && wr && addr == ADDR_IRQ_EN) begin
            enCopy <= wdata[4:0];
        end else if (take && wr && addr == ADDR_DEFECT_CFG) begin
            algoCopy <= wdata[7];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_answer;
        ##1 ack ##1 !ack;
    endsequence
    sequence s_read(a);
        ack && !wr && addr == a;
    endsequence

    property p_answer;
        take |-> s_answer;
    endproperty
    a_answer: assert property (p_answer)
        else $error("link request not answered by one ack pulse");
    property p_held;
        take |=> sel && $stable(addr) && $stable(wr) && $stable(wdata);
    endproperty
    a_held: assert property (p_held)
        else $error("link request dropped before ack");
    property p_en_rb;
        s_read(ADDR_IRQ_EN) |-> rdata == {3'b000, enCopy};
    endproperty
    a_en_rb: assert property (p_en_rb)
        else $error("enable register read differs from last write");
    property p_stat_hi;
        s_read(ADDR_IRQ_STAT) |-> rdata[7:5] == 3'b000;
    endproperty
    a_stat_hi: assert property (p_stat_hi)
        else $error("unused status bits read nonzero");
    property p_cfg_rb;
        s_read(ADDR_DEFECT_CFG) |-> rdata[7] == algoCopy;
    endproperty
    a_cfg_rb: assert property (p_cfg_rb)
        else $error("algorithm select read differs from last write");
    property p_unmapped;
        ack && !wr && !(addr inside {8'h11, 8'h12, 8'h14}) |-> rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read returned nonzero");
    property p_masked;
        enCopy == 5'h00 && $past(enCopy) == 5'h00 |-> intN;
    endproperty
    a_masked: assert property (p_masked)
        else $error("request line low with all enables clear");
    property p_fall;
        $fell(intN) |-> enCopy != 5'h00;
    endproperty
    a_fall: assert property (p_fall)
        else $error("request line fell with no enable set");
    property p_hold;
        !$stable(rdata) |-> ack && $past(sel);
    endproperty
    a_hold: assert property (p_hold)
        else $error("read data changed outside an answer");
endmodule // e3ra_checker

`default_nettype wire

// [testbench.sv]
// Self-checking bench joining host controller and alarm device.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import e3ra_pkg::*;

    logic clock, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic frameTick, fasError, resyncDone, bitValid, bitData, losState;
    logic payloadUnstable, traceMark, farEndFailure;
    logic oofState, lofState, aisState;
    logic [11:0] resyncAlign, extractAlign;
    int seed = 25299;
    int num_errors = 0;
    int compares = 0;
    int cyc = 0;

    always #10 clock = ~clock;

    e3ra_link_if lnk();
    e3ra_device #(.LOF_SHORT_CYC(8), .LOF_LONG_CYC(20)) u_e3ra_device (
        .clock(clock), .sys_rst(sys_rst), .lnk(lnk),
        .frameTick(frameTick), .fasError(fasError),
        .resyncDone(resyncDone), .resyncAlign(resyncAlign),
        .bitValid(bitValid), .bitData(bitData), .losState(losState),
        .payloadUnstable(payloadUnstable), .traceMark(traceMark),
        .farEndFailure(farEndFailure), .extractAlign(extractAlign),
        .oofState(oofState), .lofState(lofState), .aisState(aisState));
    e3ra_host u_e3ra_host (
        .clock(clock), .sys_rst(sys_rst), .lnk(lnk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq));
    e3ra_checker u_e3ra_checker (
        .clock(clock), .sys_rst(sys_rst), .sel(lnk.sel), .wr(lnk.wr),
        .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata),
        .ack(lnk.ack), .intN(lnk.intN));

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] got,
                       input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // A device access is a command write, then status polls until idle.
    task automatic dev(input logic w, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] r);
        logic [31:0] s;
        apb(1'b1, APB_CMD, {14'h0000, 1'b1, w, d, a}, s);
        s = 32'h0000_0100;
        while (s[8] !== 1'b0) apb(1'b0, APB_STAT, 32'h0000_0000, s);
        r = s[7:0];
    endtask

    // Random length and zero placement; the count of zeros stays exact.
    task automatic frame(input int nz, input logic err);
        int len;
        int off;
        len = 16 + {$random(seed)} % 16;
        off = {$random(seed)} % len;
        for (int i = 0; i < len; i++) begin
            @(posedge clock);
            bitValid <= 1'b1;
            bitData <= ((i + off) % len) >= nz;
            frameTick <= (i == len - 1);
            fasError <= err;
        end
        @(posedge clock);
        bitValid <= 1'b0;
        frameTick <= 1'b0;
        @(negedge clock);
    endtask

    task automatic resync(input logic [11:0] a);
        @(posedge clock);
        resyncDone <= 1'b1;
        resyncAlign <= a;
        @(posedge clock);
        resyncDone <= 1'b0;
        @(negedge clock);
    endtask

    task automatic lose();
        repeat (3) frame(12, 1'b1);
        chk("oof early", oofState, 1'b0);
        frame(12, 1'b1);
        chk("oof set", oofState, 1'b1);
    endtask

    function automatic logic [7:0] expCfg(input logic algo, loss_of_frame, out_of_frame, ais);
        expCfg = {algo, loss_of_frame, out_of_frame, losState, ais, payloadUnstable, traceMark,
                  farEndFailure};
    endfunction

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        logic [7:0] b;
        logic [7:0] v;
        logic [11:0] al;
        clock = 1'b0;
        sys_rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {frameTick, fasError, resyncDone, resyncAlign} = '0;
        {bitValid, bitData, losState} = '0;
        {payloadUnstable, traceMark, farEndFailure} = 3'($random(seed));
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        @(negedge clock);
        chk("intN idle", lnk.intN, 1'b1);
        dev(1'b0, ADDR_IRQ_EN, 8'h00, b);
        chk("en reset", b, 8'h00);
        dev(1'b0, 8'h20, 8'h00, b);
        chk("link unmapped", b, 8'h00);
        apb(1'b0, 8'h10, 32'h0000_0000, r);
        chk("apb unmapped", r, 32'h0000_0000);
        chk("no slave error", pslverr, 1'b0);
        for (int i = 0; i < 3; i++) begin
            v = 8'($random(seed));
            dev(1'b1, ADDR_IRQ_EN, v, b);
            dev(1'b0, ADDR_IRQ_EN, 8'h00, b);
            chk("en readback", b, {3'b000, v[4:0]});
        end
        dev(1'b1, ADDR_IRQ_EN, 8'hFF, b);
        dev(1'b1, ADDR_IRQ_STAT, 8'hFF, b);
        dev(1'b0, ADDR_IRQ_STAT, 8'h00, b);
        chk("stat write", b, 8'h00);
        apb(1'b1, APB_IMASK, 32'h0000_0003, r);
        apb(1'b1, APB_ISTAT, 32'h0000_0003, r);
        repeat (2) frame(2, 1'b0);
        chk("ais set", aisState, 1'b1);
        repeat (2) @(negedge clock);
        chk("intN low", lnk.intN, 1'b0);
        chk("irq high", irq, 1'b1);
        apb(1'b0, APB_ISTAT, 32'h0000_0000, r);
        chk("istat fell", r[1], 1'b1);
        dev(1'b0, ADDR_IRQ_STAT, 8'h00, b);
        chk("ais flag", b, 8'h01);
        @(negedge clock);
        chk("intN release", lnk.intN, 1'b1);
        dev(1'b0, ADDR_DEFECT_CFG, 8'h00, b);
        chk("cfg ais", b, expCfg(1'b0, 1'b0, 1'b0, 1'b1));
        dev(1'b0, ADDR_IRQ_STAT, 8'h00, b);
        chk("read clear", b, 8'h00);
        apb(1'b1, APB_ISTAT, 32'h0000_0003, r);
        apb(1'b0, APB_ISTAT, 32'h0000_0000, r);
        chk("istat w1c", r, 32'h0000_0000);
        @(negedge clock);
        chk("irq low", irq, 1'b0);
        for (int i = 0; i < 4; i++) begin
            frame((i == 1) ? 7 : 8, 1'b0);
            chk("ais clear", aisState, i < 3);
        end
        dev(1'b0, ADDR_IRQ_STAT, 8'h00, b);
        chk("ais cleared flag", b, 8'h01);
        @(posedge clock);
        losState <= 1'b1;
        dev(1'b0, ADDR_IRQ_STAT, 8'h00, b);
        chk("los flag", b, 8'h02);
        lose();
        chk("align held", extractAlign, 12'h000);
        repeat (4) @(negedge clock);
        chk("lof early", lofState, 1'b0);
        repeat (8) @(negedge clock);
        chk("lof short", lofState, 1'b1);
        dev(1'b0, ADDR_IRQ_STAT, 8'h00, b);
        chk("lof flag", b, 8'h0C);
        resync(12'h000);
        chk("in frame", {oofState, lofState}, 2'b00);
        dev(1'b0, ADDR_IRQ_STAT, 8'h00, b);
        chk("same align", b, 8'h0C);
        lose();
        al = 12'($random(seed)) | 12'h001;
        resync(al);
        chk("new align", extractAlign, al);
        dev(1'b0, ADDR_IRQ_STAT, 8'h00, b);
        chk("align flag", b, 8'h18);
        dev(1'b1, ADDR_DEFECT_CFG, 8'hFF, b);
        dev(1'b0, ADDR_DEFECT_CFG, 8'h00, b);
        chk("cfg algo", b, expCfg(1'b1, 1'b0, 1'b0, 1'b0));
        lose();
        chk("align kept", extractAlign, al);
        repeat (12) @(negedge clock);
        chk("lof long early", lofState, 1'b0);
        repeat (12) @(negedge clock);
        chk("lof long", lofState, 1'b1);
        resync(al);
        dev(1'b0, ADDR_IRQ_STAT, 8'h00, b);
        chk("long flags", b, 8'h0C);
        dev(1'b1, ADDR_IRQ_EN, 8'h00, b);
        lose();
        resync(~al);
        chk("masked intN", lnk.intN, 1'b1);
        dev(1'b0, ADDR_IRQ_STAT, 8'h00, b);
        chk("masked flags", b, 8'h00);
        wrap_up();
    end
endmodule // testbench

`default_nettype wire
